/* bels_regs.vh */
/*
 Constants for the boot entry and interface select block: addresses,
 option values, sync tokens, interface indices and timing.
 Assumes a 100 MHz system clock.
*/
`ifndef BELS_REGS_VH
`define BELS_REGS_VH

`define BELS_BOOT_ROM_RESET_ADDR 16'h6000
`define BELS_APP_RESET_ADDR 16'h8000
`define BELS_APP_VECTOR_BASE 16'h8004
`define BELS_OPT_BOOT_ADDR 16'h487E
`define BELS_OPT_BOOT_N_ADDR 16'h487F

`define BELS_OPCODE_A 8'h82
`define BELS_OPCODE_B 8'hAC
`define BELS_OPT_BOOT_EN 8'h55
`define BELS_OPT_BOOT_EN_N 8'hAA
`define BELS_ROP_ACTIVE 8'hAA
`define BELS_SYNC_TOKEN 8'h7F

`define BELS_NUM_IF 5
`define BELS_IF_UART1 0
`define BELS_IF_UART2 1
`define BELS_IF_UART3 2
`define BELS_IF_SPI 3
`define BELS_IF_CAN 4

`define BELS_CLK_HZ 100000000
`define BELS_TIMEOUT_MS 1000
`define BELS_TIMEOUT_CYC ((`BELS_CLK_HZ / 1000) * `BELS_TIMEOUT_MS)
`define BELS_HSI_MHZ 8'h10
`define BELS_CAN_KBPS 16'h007D

`endif

/* bels_sync3.v */
/*
 Three-stage synchroniser with agreement filter for one pin input.
 Assumes the pin is asynchronous to clk.
*/
`default_nettype none

module bels_sync3
(
    // Clock and reset
    input wire clk,
    input wire rst_n,
    input wire clk_en,
    // Pin and filtered level
    input wire pin,
    output reg level_q
);

reg s1_q;
reg s2_q;
reg s3_q;

always @(posedge clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        s1_q <= 1'b0;
        s2_q <= 1'b0;
        s3_q <= 1'b0;
        level_q <= 1'b0;
    end
    else if (clk_en)
    begin
        s1_q <= pin;
        s2_q <= s1_q;
        s3_q <= s2_q;
        if (s2_q == s3_q)
        begin
            level_q <= s3_q;
        end
    end
end

endmodule // bels_sync3

`default_nettype wire

/* bels_top.v */
/*
 Boot entry decision and serial interface selection.
 Assumes memory bytes are valid while mem_valid is high, that interface
 receivers report sync events as one-cycle pulses on clk, and that the
 external clock present flag comes from a pin.
*/
// How it works
// RL1: Boot vector points into boot ROM at every reset release.
// RL2: Other interrupt vectors come from flash base address.
// RL3: Without boot, application starts at first flash address.
// RL4: Interrupts disabled first thing on boot entry.
// RL5: First flash byte not a valid opcode means virgin: enter boot.
// RL6: Valid first byte plus option pair 55h/AAh still enters boot.
// RL7: Valid first byte without enabling pair starts application.
// RL8: Protection level AAh stops boot, starts application.
// RL9: CAN only polled when a supported external clock is present.
// RL10: CAN set to 125 kbps when used.
// RL11: Oscillator 16 MHz, receive pins pulled up, SPI slave before polling.
// RL12: Poll all interfaces for sync, one second timeout.
// RL13: Timeout: virgin waits forever, else reset registers and run app.
// RL14: Host resets device after a wrong byte on an async port.
// RL15: Wrong CAN or SPI message keeps polling.
// RL16: Async port sync measures baud before commands; CAN, SPI direct.
// RL17: Sync locks one interface and disables the rest.
// RL18: Commands loop until the host sends jump.
// RL19: Jump clears helper routines before leaving.
// RL20: Write-protection test runs after interface setup.
// RL21: Host sends 7Fh on an async port for sync.
// RL22: Host puts 7Fh in the CAN receive identifier.
// RL23: Timeout counted on the internal oscillator clock.
`default_nettype none
`include "bels_regs.vh"

module bels_top
#(
    parameter TIMEOUT_CYC = `BELS_TIMEOUT_CYC,
    parameter NUM_IF = `BELS_NUM_IF
)
(
    // Clock and reset
    input wire clk,
    input wire rst_n,
    input wire clk_en,
    // Memory and option bytes
    input wire mem_valid,
    input wire [7:0] first_flash_byte,
    input wire [7:0] boot_enable_option,
    input wire [7:0] boot_enable_option_complement,
    input wire [7:0] readout_protection_level,
    // External clock pin
    input wire ext_clk_present_pin,
    // Interface events
    input wire [NUM_IF-1:0] sync_seen,
    input wire [NUM_IF-1:0] bad_seen,
    input wire baud_done,
    input wire wp_test_done,
    input wire cmd_jump,
    input wire [15:0] jump_addr,
    // Control outputs
    output reg [15:0] fetch_addr_q,
    output reg [15:0] vector_base_q,
    output reg irq_enable_q,
    output reg [7:0] internal_rc_oscillator_mhz_q,
    output reg rx_pullup_q,
    output reg spi_slave_q,
    output reg [15:0] can_kbps_q,
    output reg [NUM_IF-1:0] if_enable_q,
    output reg baud_measure_q,
    output reg wp_test_q,
    output reg cmd_active_q,
    output reg erase_helper_routine_clear_q,
    output reg write_helper_routine_clear_q,
    output reg regs_restore_q,
    output reg app_start_q,
    output reg [3:0] state_q
);

// ----------------------------------------------------------------
// States
// ----------------------------------------------------------------
localparam [9:0] ST_CHECK = 10'h001;
localparam [9:0] ST_INIT = 10'h002;
localparam [9:0] ST_WPTEST = 10'h004;
localparam [9:0] ST_POLL = 10'h008;
localparam [9:0] ST_WAIT = 10'h010;
localparam [9:0] ST_BAUD = 10'h020;
localparam [9:0] ST_CMD = 10'h040;
localparam [9:0] ST_CLEAN = 10'h080;
localparam [9:0] ST_APP = 10'h100;
localparam [9:0] ST_RUN = 10'h200;

localparam [31:0] TMO_LAST = TIMEOUT_CYC - 1;
localparam [NUM_IF-1:0] ALL_IF = {NUM_IF{1'b1}};
localparam [NUM_IF-1:0] ONE_IF = {{(NUM_IF-1){1'b0}}, 1'b1};
localparam [NUM_IF-1:0] CAN_BIT = ONE_IF << `BELS_IF_CAN;
localparam [NUM_IF-1:0] ASYNC_MASK = (ONE_IF << `BELS_IF_UART1)
    | (ONE_IF << `BELS_IF_UART2) | (ONE_IF << `BELS_IF_UART3);

reg [9:0] st_q;
reg [9:0] st_d;
reg [31:0] tmo_q;
reg virgin_q;
reg [NUM_IF-1:0] dead_q;
wire ext_clk_present;
wire [NUM_IF-1:0] usable;
wire [NUM_IF-1:0] sync_hit;
wire [NUM_IF-1:0] first_hit;
wire is_virgin;
wire boot_opt;

// ----------------------------------------------------------------
// External clock pin filter
// ----------------------------------------------------------------
bels_sync3 u_ext_sync
(
    .clk(clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .pin(ext_clk_present_pin),
    .level_q(ext_clk_present)
);

// ----------------------------------------------------------------
// Entry decision
// ----------------------------------------------------------------
assign is_virgin = (first_flash_byte != `BELS_OPCODE_A)
    && (first_flash_byte != `BELS_OPCODE_B); // [RL5]
assign boot_opt = (boot_enable_option == `BELS_OPT_BOOT_EN)
    && (boot_enable_option_complement == `BELS_OPT_BOOT_EN_N); // [RL6]

// CAN dropped without external clock; async ports dead after a wrong byte
assign usable = if_enable_q & ~dead_q & (ext_clk_present ? ALL_IF : ~CAN_BIT); // [RL9] [RL14]
assign sync_hit = sync_seen & usable;
assign first_hit = sync_hit & (~sync_hit + ONE_IF); // [RL17]

always @*
begin
    st_d = st_q;
    case (st_q)
        ST_CHECK:
        begin
            if (mem_valid)
            begin
                if (readout_protection_level == `BELS_ROP_ACTIVE)
                begin
                    st_d = ST_APP; // [RL8]
                end
                else if (is_virgin || boot_opt)
                begin
                    st_d = ST_INIT; // [RL5] [RL6]
                end
                else
                begin
                    st_d = ST_APP; // [RL7]
                end
            end
        end
        ST_INIT: st_d = ST_WPTEST;
        ST_WPTEST: if (wp_test_done) st_d = ST_POLL; // [RL20]
        ST_POLL:
        begin
            if (|first_hit)
            begin
                st_d = (|(first_hit & ASYNC_MASK)) ? ST_BAUD : ST_CMD; // [RL16]
            end
            else if (tmo_q == TMO_LAST)
            begin
                st_d = virgin_q ? ST_WAIT : ST_APP; // [RL13]
            end
        end
        ST_WAIT:
        begin
            if (|first_hit)
            begin
                st_d = (|(first_hit & ASYNC_MASK)) ? ST_BAUD : ST_CMD; // [RL16]
            end
        end
        ST_BAUD: if (baud_done) st_d = ST_CMD; // [RL16]
        ST_CMD: if (cmd_jump) st_d = ST_CLEAN; // [RL18]
        ST_CLEAN: st_d = ST_RUN; // [RL19]
        ST_APP: st_d = ST_RUN;
        ST_RUN: st_d = ST_RUN;
        default: st_d = ST_CHECK;
    endcase
end

// ----------------------------------------------------------------
// Sequencer and outputs
// ----------------------------------------------------------------
always @(posedge clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        st_q <= ST_CHECK;
        tmo_q <= 32'h0000_0000;
        virgin_q <= 1'b0;
        dead_q <= {NUM_IF{1'b0}};
        fetch_addr_q <= `BELS_BOOT_ROM_RESET_ADDR; // [RL1]
        vector_base_q <= `BELS_APP_VECTOR_BASE; // [RL2]
        irq_enable_q <= 1'b0; // [RL4]
        internal_rc_oscillator_mhz_q <= 8'h00;
        rx_pullup_q <= 1'b0;
        spi_slave_q <= 1'b0;
        can_kbps_q <= 16'h0000;
        if_enable_q <= {NUM_IF{1'b0}};
        baud_measure_q <= 1'b0;
        wp_test_q <= 1'b0;
        cmd_active_q <= 1'b0;
        erase_helper_routine_clear_q <= 1'b0;
        write_helper_routine_clear_q <= 1'b0;
        regs_restore_q <= 1'b0;
        app_start_q <= 1'b0;
        state_q <= 4'h0;
    end
    else if (clk_en)
    begin
        st_q <= st_d;
        erase_helper_routine_clear_q <= 1'b0;
        write_helper_routine_clear_q <= 1'b0;
        regs_restore_q <= 1'b0;
        app_start_q <= 1'b0;
        case (st_q)
            ST_CHECK:
            begin
                irq_enable_q <= 1'b0; // [RL4]
                if (mem_valid)
                begin
                    virgin_q <= is_virgin;
                end
                state_q <= 4'h0;
            end
            ST_INIT:
            begin
                internal_rc_oscillator_mhz_q <= `BELS_HSI_MHZ; // [RL11]
                rx_pullup_q <= 1'b1; // [RL11]
                spi_slave_q <= 1'b1; // [RL11]
                if (ext_clk_present)
                begin
                    can_kbps_q <= `BELS_CAN_KBPS; // [RL10]
                end
                if_enable_q <= ext_clk_present ? ALL_IF : ~CAN_BIT; // [RL9]
                wp_test_q <= 1'b1;
                state_q <= 4'h1;
            end
            ST_WPTEST:
            begin
                tmo_q <= 32'h0000_0000;
                if (wp_test_done)
                begin
                    wp_test_q <= 1'b0; // [RL20]
                end
                state_q <= 4'h2;
            end
            ST_POLL, ST_WAIT:
            begin
                // Timeout runs on clk, which derives from the internal oscillator
                if (st_q == ST_POLL)
                begin
                    tmo_q <= tmo_q + 32'h0000_0001; // [RL12] [RL23]
                end
                dead_q <= dead_q | (bad_seen & ASYNC_MASK & ~sync_seen); // [RL14] [RL15]
                if (|first_hit)
                begin
                    if_enable_q <= first_hit; // [RL17]
                    baud_measure_q <= |(first_hit & ASYNC_MASK); // [RL16]
                end
                else if (st_q == ST_POLL && tmo_q == TMO_LAST && !virgin_q)
                begin
                    regs_restore_q <= 1'b1; // [RL13]
                end
                state_q <= (st_q == ST_POLL) ? 4'h3 : 4'h4;
            end
            ST_BAUD:
            begin
                if (baud_done)
                begin
                    baud_measure_q <= 1'b0;
                    cmd_active_q <= 1'b1; // [RL16]
                end
                state_q <= 4'h5;
            end
            ST_CMD:
            begin
                cmd_active_q <= ~cmd_jump; // [RL18]
                if (cmd_jump)
                begin
                    erase_helper_routine_clear_q <= 1'b1; // [RL19]
                    write_helper_routine_clear_q <= 1'b1; // [RL19]
                    fetch_addr_q <= jump_addr;
                end
                state_q <= 4'h6;
            end
            ST_CLEAN:
            begin
                if_enable_q <= {NUM_IF{1'b0}};
                app_start_q <= 1'b1;
                state_q <= 4'h7;
            end
            ST_APP:
            begin
                fetch_addr_q <= `BELS_APP_RESET_ADDR; // [RL3] [RL13]
                if_enable_q <= {NUM_IF{1'b0}};
                app_start_q <= 1'b1; // [RL3]
                state_q <= 4'h8;
            end
            ST_RUN:
            begin
                state_q <= 4'h9;
            end
            default:
            begin
                state_q <= 4'hF;
            end
        endcase
    end
end

endmodule // bels_top

`default_nettype wire

/* bels_top_assertions.sv */
/*
 Port-level checker for bels_top, bound into every instance.
 Assumes clk_en stays high and state codes as the block publishes them.
*/
`default_nettype none
module bels_chk #(parameter TIMEOUT_CYC = 50)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Watched outputs
    input wire logic [15:0] fetch_addr_q,
    input wire logic [15:0] vector_base_q,
    input wire logic irq_enable_q,
    input wire logic [7:0] internal_rc_oscillator_mhz_q,
    input wire logic rx_pullup_q,
    input wire logic spi_slave_q,
    input wire logic [15:0] can_kbps_q,
    input wire logic [4:0] if_enable_q,
    input wire logic baud_measure_q,
    input wire logic wp_test_q,
    input wire logic cmd_active_q,
    input wire logic erase_helper_routine_clear_q,
    input wire logic write_helper_routine_clear_q,
    input wire logic regs_restore_q,
    input wire logic app_start_q,
    input wire logic [3:0] state_q
);
    timeunit 1ns;
    timeprecision 1ps;
    int poll_q;
    always @(posedge clk or negedge rst_n)
        if (!rst_n)
            poll_q <= 0;
        else
            poll_q <= (state_q == 4'h3) ? poll_q + 1 : 0;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    AST_BOOT_VEC: assert property (state_q == 4'h0 |-> fetch_addr_q == 16'h6000)
        else $error("fetch left boot ROM before decision");
    AST_VEC_BASE: assert property (vector_base_q == 16'h8004)
        else $error("vector base wrong");
    AST_IRQ_OFF: assert property (!irq_enable_q)
        else $error("interrupts enabled");
    AST_WP_AFTER_INIT: assert property (wp_test_q |-> internal_rc_oscillator_mhz_q == 8'h10 && rx_pullup_q)
        else $error("protection test before setup");
    AST_POLL_SETUP: assert property (state_q == 4'h3 |-> spi_slave_q && rx_pullup_q)
        else $error("polling without pin setup");
    AST_CAN_RATE: assert property (can_kbps_q != 16'h0000 |-> can_kbps_q == 16'h007D)
        else $error("CAN rate wrong");
    AST_CAN_CLK: assert property (if_enable_q[4] |-> can_kbps_q == 16'h007D)
        else $error("CAN used without clock");
    AST_LOCK: assert property (cmd_active_q |-> $onehot(if_enable_q))
        else $error("more than one interface live");
    AST_BAUD_ASYNC: assert property (baud_measure_q |-> $onehot(if_enable_q) && if_enable_q[4:3] == 2'b00)
        else $error("baud measure on sync port");
    AST_JUMP_CLEAN: assert property ($rose(erase_helper_routine_clear_q) |-> write_helper_routine_clear_q ##[1:3] app_start_q)
        else $error("jump without helper clear");
    AST_RESTORE_APP: assert property (regs_restore_q |-> ##[1:4] (fetch_addr_q == 16'h8000 && if_enable_q == 5'h00))
        else $error("restore not followed by app");
    AST_TIMEOUT: assert property (poll_q <= TIMEOUT_CYC)
        else $error("poll exceeded timeout");
endmodule // bels_chk
bind bels_top bels_chk #(.TIMEOUT_CYC(TIMEOUT_CYC)) bels_chk_i (.clk, .rst_n, .fetch_addr_q, .vector_base_q,
    .irq_enable_q, .internal_rc_oscillator_mhz_q, .rx_pullup_q, .spi_slave_q, .can_kbps_q, .if_enable_q,
    .baud_measure_q, .wp_test_q, .cmd_active_q, .erase_helper_routine_clear_q, .write_helper_routine_clear_q,
    .regs_restore_q, .app_start_q, .state_q);
`default_nettype wire

/* bels_host.sv */
/*
 Host programmer model: serial events as one-cycle pulses.
 Assumes its tasks are called from the bench after a clock edge.
*/
`default_nettype none
module bels_host
(
    // Clock
    input wire logic clk,
    // Events toward the block
    output logic [4:0] sync_seen,
    output logic [4:0] bad_seen,
    output logic baud_done,
    output logic cmd_jump,
    output logic [15:0] jump_addr
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        sync_seen = 5'h00;
        bad_seen = 5'h00;
        baud_done = 1'b0;
        cmd_jump = 1'b0;
        jump_addr = 16'hFFFF;
    end
    task automatic send(input logic good, input int idx);
        @(posedge clk);
        #1;
        if (good)
            sync_seen[idx] = 1'b1;
        else
            bad_seen[idx] = 1'b1;
        @(posedge clk);
        #1;
        sync_seen = 5'h00;
        bad_seen = 5'h00;
    endtask
    task baud;
        @(posedge clk);
        #1 baud_done = 1'b1;
        @(posedge clk);
        #1 baud_done = 1'b0;
    endtask
    task jump(input logic [15:0] a);
        @(posedge clk);
        #1 cmd_jump = 1'b1;
        jump_addr = a;
        @(posedge clk);
        #1 cmd_jump = 1'b0;
        jump_addr = ~a;
    endtask
endmodule // bels_host
`default_nettype wire

/* bels_tb.sv */
/*
 Self-checking bench for bels_top with the host model.
 Assumes a shortened timeout of 50 cycles.
*/
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst_n, mem_valid, ext_clk_present_pin, wp_test_done, baud_done, cmd_jump, wp_test_q;
    logic [7:0] first_flash_byte, boot_enable_option, boot_enable_option_complement, readout_protection_level;
    logic [4:0] sync_seen, bad_seen, if_enable_q;
    logic [15:0] jump_addr, fetch_addr_q, can_kbps_q;
    logic [3:0] state_q;
    int bad_count = 0;
    int n_tests = 0;
    bels_top #(.TIMEOUT_CYC(50)) bels_top_i (.clk, .rst_n, .clk_en(1'b1), .mem_valid, .first_flash_byte,
        .boot_enable_option, .boot_enable_option_complement, .readout_protection_level, .ext_clk_present_pin,
        .sync_seen, .bad_seen, .baud_done, .wp_test_done, .cmd_jump, .jump_addr, .fetch_addr_q,
        .vector_base_q(), .irq_enable_q(), .internal_rc_oscillator_mhz_q(), .rx_pullup_q(), .spi_slave_q(),
        .can_kbps_q, .if_enable_q, .baud_measure_q(), .wp_test_q, .cmd_active_q(),
        .erase_helper_routine_clear_q(), .write_helper_routine_clear_q(), .regs_restore_q(), .app_start_q(),
        .state_q);
    bels_host bels_host_i (.clk, .sync_seen, .bad_seen, .baud_done, .cmd_jump, .jump_addr);
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    //----------------------------------------
    // Access tasks
    //----------------------------------------
    task end_of_test;
        $display("checks=%0d mismatches=%0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task waitst(input logic [3:0] s);
        int i;
        i = 0;
        while (state_q !== s && i < 300)
        begin
            @(posedge clk);
            #2;
            i++;
        end
        chk(16'(state_q), 16'(s));
        if (state_q !== s)
            end_of_test;
    endtask
    task pause(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask
    task pulse_wp;
        @(posedge clk);
        #1 wp_test_done = 1'b1;
        @(posedge clk);
        #1 wp_test_done = 1'b0;
    endtask
    task boot(input logic [7:0] f, o, on, rp, input logic ek, input logic [3:0] exp);
        int i;
        rst_n = 1'b0;
        mem_valid = 1'b0;
        first_flash_byte = f;
        boot_enable_option = o;
        boot_enable_option_complement = on;
        readout_protection_level = rp;
        ext_clk_present_pin = ek;
        repeat (8) @(posedge clk);
        #1 rst_n = 1'b1;
        repeat (6) @(posedge clk);
        #1 mem_valid = 1'b1;
        i = 0;
        while (state_q !== 4'h2 && state_q !== 4'h9 && i < 20)
        begin
            pause(1);
            i++;
        end
        chk(16'(state_q), 16'(exp));
        if (i == 20)
            end_of_test;
        if (exp == 4'h9)
            chk(fetch_addr_q, 16'h8000);
        else
            chk(16'(wp_test_q), 16'h0001);
    endtask
    initial
    begin
        wp_test_done = 1'b0;
        boot(8'h00, 8'h00, 8'h00, 8'h00, 1'b0, 4'h2);
        boot(8'hAC, 8'h55, 8'hAA, 8'h00, 1'b0, 4'h2);
        boot(8'h82, 8'h00, 8'h00, 8'h00, 1'b0, 4'h9);
        boot(8'hAC, 8'h55, 8'h00, 8'h00, 1'b0, 4'h9);
        boot(8'h00, 8'h00, 8'h00, 8'hAA, 1'b0, 4'h9);
        boot(8'h82, 8'h55, 8'hAA, 8'hAA, 1'b0, 4'h9);
        boot(8'h82, 8'h55, 8'hAA, 8'h00, 1'b0, 4'h2);
        pulse_wp;
        waitst(4'h9);
        chk(fetch_addr_q, 16'h8000);
        boot(8'h00, 8'h00, 8'h00, 8'h00, 1'b0, 4'h2);
        chk(can_kbps_q, 16'h0000);
        pulse_wp;
        waitst(4'h4);
        pause(60);
        chk(16'(state_q), 16'h0004);
        bels_host_i.send(1'b0, 3);
        bels_host_i.send(1'b1, 4);
        pause(3);
        chk(16'(state_q), 16'h0004);
        bels_host_i.send(1'b1, 3);
        waitst(4'h6);
        chk(16'(if_enable_q), 16'h0008);
        bels_host_i.jump(16'h9ABC);
        waitst(4'h9);
        chk(fetch_addr_q, 16'h9ABC);
        boot(8'h00, 8'h00, 8'h00, 8'h00, 1'b1, 4'h2);
        chk(can_kbps_q, 16'h007D);
        pulse_wp;
        waitst(4'h3);
        bels_host_i.send(1'b0, 0);
        bels_host_i.send(1'b1, 0);
        pause(3);
        chk(16'(state_q), 16'h0003);
        bels_host_i.send(1'b1, 1);
        waitst(4'h5);
        chk(16'(if_enable_q), 16'h0002);
        bels_host_i.baud;
        waitst(4'h6);
        boot(8'h00, 8'h00, 8'h00, 8'h00, 1'b1, 4'h2);
        pulse_wp;
        bels_host_i.send(1'b1, 4);
        waitst(4'h6);
        chk(16'(if_enable_q), 16'h0010);
        end_of_test;
    end
endmodule // tb
`default_nettype wire
